// [hdl/eeprom_seq_pkg.sv]
package eeprom_seq_pkg;

   // ---------------------------------------------------------------------
   // array geometry
   // ---------------------------------------------------------------------
   localparam int          WORD_W          = 16;
   localparam int          ADDR_W          = 6;
   localparam logic [5:0]  FIRST_ADDR      = 6'h00;
   localparam logic [5:0]  LAST_ADDR       = 6'h3f;
   localparam logic [5:0]  GROUP_STEP      = 6'h04;
   localparam logic [5:0]  PRE_FINAL_GROUP = 6'h38;
   localparam logic [5:0]  FINAL_GROUP     = 6'h3c;

   // ---------------------------------------------------------------------
   // frame settings (field codes, bits = code + 1)
   // ---------------------------------------------------------------------
   localparam logic [3:0]  LEN_CODE_9      = 4'h8;
   localparam logic [3:0]  LEN_CODE_16     = 4'hf;
   localparam logic [3:0]  LEN_CODE_MAX    = 4'hf;
   localparam logic [1:0]  SEQ_ONE         = 2'h0;
   localparam logic [1:0]  SEQ_FOUR        = 2'h3;
   localparam logic        CPHA_CMD        = 1'b0;
   localparam logic        CPHA_DATA       = 1'b1;
   localparam logic        HOLD_SELECT     = 1'b1;
   localparam logic        RELEASE_SELECT  = 1'b0;
   localparam logic [15:0] POLL_WORD       = 16'h0000;
   localparam logic [8:0]  POLL_DONE       = 9'h1ff;

   // ---------------------------------------------------------------------
   // link timing
   // ---------------------------------------------------------------------
   localparam int          SYS_CLK_HZ      = 25_000_000;
   localparam int          LINK_CLK_HZ     = 8_000_000;
   localparam int          SCLK_HZ         = 2_000_000;
   localparam int          LINK_PER_SCLK   = LINK_CLK_HZ / SCLK_HZ;
   localparam logic [1:0]  PH_RISE         = 2'h1;
   localparam logic [1:0]  PH_FALL         = 2'h3;

   // one frame handed to the link engine
   typedef struct packed {
      logic [3:0]  frame_length_field;
      logic        select_hold_field;
      logic        cpha;
      logic [15:0] tx;
   } frame_cmd_t;

   // serial pins driven toward the memory
   typedef struct packed {
      logic master_serial_clock;
      logic mosi;
      logic slave_select_line;
   } spi_pins_t;

endpackage

// [hdl/spi_frame_link.sv]
`timescale 1ns/1ps
module spi_frame_link (
   input  wire logic                     link_clk_in,   // link clock
   input  wire logic                     arst_n_in,     // async reset
   input  wire logic                     req_tgl_in,    // toggles per frame
   input  wire eeprom_seq_pkg::frame_cmd_t cmd_in,      // stable while req
   input  wire logic                     miso_in,       // from memory pin
   output logic                          ack_tgl_out,   // toggles at end
   output logic [15:0]                   rx_out,        // received bits
   output eeprom_seq_pkg::spi_pins_t     pins_out       // serial pins
);
   import eeprom_seq_pkg::*;

   typedef struct packed {
      logic        req_s1;
      logic        req_s2;
      logic        req_seen;
      logic        miso_s1;
      logic        miso_s2;
      logic        run;
      logic        pend;
      logic        ack;
      logic [1:0]  ph;
      logic [4:0]  edges;
      logic [4:0]  len;
      logic        cpha;
      logic        keep;
      logic [15:0] sh;
      logic [15:0] rx;
      logic [15:0] rx_hold;
      spi_pins_t   pins;
   } link_state_t;

   link_state_t q;
   link_state_t next_q;
   logic        active;
   logic [15:0] aligned;

   // ---------------------------------------------------------------------
   // frame engine, four link cycles per serial bit
   // ---------------------------------------------------------------------
   // clock keeps toggling until the last sampling edge, then returns low
   assign active  = (q.edges != q.len) || q.pins.master_serial_clock;
   // left-align so the msb leaves first whatever the length
   assign aligned = cmd_in.tx << (LEN_CODE_MAX - cmd_in.frame_length_field);

   always_comb begin
      next_q         = q;
      next_q.req_s1  = req_tgl_in;
      next_q.req_s2  = q.req_s1;
      next_q.miso_s1 = miso_in;
      next_q.miso_s2 = q.miso_s1;
      if (!q.run) begin
         if (q.req_s2 != q.req_seen) begin
            next_q.req_seen = q.req_s2;
            next_q.run      = 1'b1;
            next_q.ph       = 2'h0;
            next_q.edges    = 5'h00;
            next_q.len      = {1'b0, cmd_in.frame_length_field} + 5'h01;
            next_q.cpha     = cmd_in.cpha;
            next_q.keep     = cmd_in.select_hold_field;
            next_q.sh       = aligned;
            next_q.rx       = 16'h0000;
            next_q.pins.slave_select_line = 1'b1;
            next_q.pins.mosi = cmd_in.cpha ? 1'b0 : aligned[15];
         end
      end else begin
         next_q.ph = q.ph + 2'h1;
         // capture two cycles after the edge, past the pin synchroniser
         if (q.pend && q.ph[0]) begin
            next_q.rx   = {q.rx[14:0], q.miso_s2};
            next_q.pend = 1'b0;
         end
         if (active && q.ph == PH_RISE) begin
            next_q.pins.master_serial_clock = 1'b1;
            if (!q.cpha) begin
               next_q.pend  = 1'b1;
               next_q.edges = q.edges + 5'h01;
            end else begin
               next_q.pins.mosi = q.sh[15];
               next_q.sh        = q.sh << 1;
            end
         end
         if (active && q.ph == PH_FALL) begin
            next_q.pins.master_serial_clock = 1'b0;
            if (q.cpha) begin
               next_q.pend  = 1'b1;
               next_q.edges = q.edges + 5'h01;
            end else begin
               next_q.pins.mosi = q.sh[14];
               next_q.sh        = q.sh << 1;
            end
         end
         if (!active && !q.pend) begin
            next_q.run       = 1'b0;
            next_q.ph        = 2'h0;
            next_q.pins.mosi = 1'b0;
            next_q.pins.slave_select_line = q.keep;
            next_q.rx_hold   = q.rx;
            next_q.ack       = ~q.ack;
         end
      end
   end

   always_ff @(posedge link_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign ack_tgl_out = q.ack;
   assign rx_out      = q.rx_hold;
   assign pins_out    = q.pins;

endmodule

// [hdl/serial_eeprom_read_erase_seq.sv]
// What this block does
// - read sequence fetches words 0x00 to 0x3f ascending, one continuous run
// - read command carries read opcode with address field zero
// - read command is one 9-bit frame, sequence length one
// - select active through read command and stays active afterwards
// - command frame changes data on falling edge, sampled on rising
// - data collected in groups of four 16-bit frames, 64 bits each
// - each read group is four frames of sixteen bits
// - data frames change on rising edge, sample on falling edge
// - filler words sent to clock data; returned bits captured
// - word counter steps by four per group, decides final group
// - final group keeps select for three frames, releases after fourth
// - final-group settings loaded during group 0x38 to 0x3b
// - erase order: write enable, erase all, poll, write disable
// - select line is active high
// - msb first, serial clock at 2 MHz from the master
// - erase polling sends 9-bit zero frames until all ones return
`timescale 1ns/1ps
module serial_eeprom_read_erase_seq #(
   parameter logic [8:0]  READ_OP      = 9'h180, // read opcode, address 0
   parameter logic [8:0]  WRITE_EN_OP  = 9'h130, // write enable frame
   parameter logic [8:0]  ERASE_ALL_OP = 9'h120, // erase all frame
   parameter logic [8:0]  WRITE_DIS_OP = 9'h100, // write disable frame
   parameter logic [15:0] FILLER_WORD  = 16'hffff // dummy transmit data
) (
   input  wire logic         clk_sys_in,            // system clock
   input  wire logic         arst_n_in,             // async reset, low
   input  wire logic         link_clk_in,           // link clock
   input  wire logic         start_read_in,         // read request pulse
   input  wire logic         start_erase_in,        // erase request pulse
   input  wire logic         miso_in,               // data from memory
   output logic              master_serial_clock_out, // serial clock
   output logic              mosi_out,              // data to memory
   output logic              slave_select_line_out, // select, high active
   output logic              busy_out,              // sequence running
   output logic              done_out,              // end pulse
   output logic [15:0]       rd_data_out,           // received word
   output logic [5:0]        rd_addr_out,           // its word address
   output logic              rd_valid_out,          // word strobe
   output logic [15:0]       poll_count_out         // polls in last erase
);
   import eeprom_seq_pkg::*;

   // ---------------------------------------------------------------------
   // sequencer state
   // ---------------------------------------------------------------------
   // sequencer states, binary coded
   typedef enum logic [2:0] {
      S_IDLE    = 3'b000,
      S_RD_CMD  = 3'b001,
      S_RD_DATA = 3'b010,
      S_ER_WEN  = 3'b011,
      S_ER_ERASE_ALL_CMD = 3'b100,
      S_ER_POLL = 3'b101,
      S_ER_WDS  = 3'b110,
      S_FINISH  = 3'b111
   } seq_state_t;

   // whole sequencer state, registered as one word
   typedef struct packed {
      seq_state_t  st;
      logic        req_tgl;
      logic        ack_s1;
      logic        ack_s2;
      logic        ack_seen;
      logic        pending;
      // frame request held toward the link domain
      frame_cmd_t  cmd;
      logic [1:0]  seq_len;
      // read progress and select-hold settings per group
      logic [5:0]  word_addr;
      logic [5:0]  group_addr;
      logic [1:0]  frame_idx;
      logic [3:0]  keep_now;
      logic [3:0]  keep_next;
      // registered outputs
      logic [15:0] data;
      logic [5:0]  data_addr;
      logic        valid;
      logic        done;
      logic        busy;
      logic [15:0] polls;
   } seq_regs_t;

   // registered state and its next value
   seq_regs_t   q;
   seq_regs_t   next_q;

   // frame bookkeeping, combinational
   logic        ack_evt;
   logic        issue;
   frame_cmd_t  issue_cmd;
   logic        issue_keep;
   logic [1:0]  next_idx;

   // link engine results, toggle and word live in the link domain
   logic        ack_tgl;
   logic [15:0] link_rx;
   spi_pins_t   pins;

   // builds one frame request from its settings
   function automatic frame_cmd_t make_frame(
      input logic [3:0]  lenc,
      input logic        hold,
      input logic        cpha,
      input logic [15:0] tx
   );
      frame_cmd_t f;
      f.frame_length_field = lenc;
      f.select_hold_field  = hold;
      f.cpha               = cpha;
      f.tx                 = tx;
      return f;
   endfunction

   // ---------------------------------------------------------------------
   // link engine, runs on the link clock
   // ---------------------------------------------------------------------
   // the command word is held steady while its toggle crosses, so the
   // engine may read it once the synchronised toggle differs
   // limitation: every frame waits for the toggle handshake, so the
   // serial clock pauses a few cycles between frames, even in a group
   spi_frame_link u_link (
      .link_clk_in (link_clk_in),
      .arst_n_in   (arst_n_in),
      .req_tgl_in  (q.req_tgl),
      .cmd_in      (q.cmd),
      .miso_in     (miso_in),
      .ack_tgl_out (ack_tgl),
      .rx_out      (link_rx),
      .pins_out    (pins)
   );

   // ---------------------------------------------------------------------
   // frame bookkeeping
   // ---------------------------------------------------------------------
   // a finished frame shows as a change of the synchronised ack toggle
   assign ack_evt  = q.pending && (q.ack_s2 != q.ack_seen);
   assign next_idx = q.frame_idx + 2'h1;
   // select-hold bit of the next data frame: the first frame of a group
   // takes the settings preloaded while the group before it ran, the
   // others those of the group already under way
   // hold per frame
   assign issue_keep = (q.frame_idx == SEQ_FOUR) ? q.keep_next[0] :
                       q.keep_now[next_idx];

   // ---------------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------------
   // one pass decides the next state and at most one new frame
   always_comb begin
      next_q        = q;
      // the ack toggle is a link-domain register: two flops before use
      next_q.ack_s1 = ack_tgl;
      next_q.ack_s2 = q.ack_s1;
      // strobes last a single cycle unless set again below
      next_q.valid  = 1'b0;
      next_q.done   = 1'b0;
      issue         = 1'b0;
      issue_cmd     = q.cmd;
      // a finished frame frees the handshake for the next request
      if (ack_evt) begin
         next_q.ack_seen = q.ack_s2;
         next_q.pending  = 1'b0;
      end

      unique case (q.st)
         // starts arriving while busy never reach this branch
         S_IDLE: begin
            if (start_read_in) begin
               next_q.st         = S_RD_CMD;
               next_q.busy       = 1'b1;
               next_q.word_addr  = FIRST_ADDR;
               next_q.group_addr = FIRST_ADDR;
               next_q.frame_idx  = 2'h0;
               // every group keeps select until told otherwise
               next_q.keep_now   = {4{HOLD_SELECT}};
               next_q.keep_next  = {4{HOLD_SELECT}};
               next_q.seq_len    = SEQ_ONE;
               issue             = 1'b1;
               issue_cmd = make_frame(LEN_CODE_9, HOLD_SELECT, CPHA_CMD,
                  {7'h00, READ_OP | {3'h0, FIRST_ADDR}});
            end else if (start_erase_in) begin
               // read wins when both starts arrive in one cycle
               next_q.st      = S_ER_WEN;
               next_q.busy    = 1'b1;
               next_q.polls   = 16'h0000;
               next_q.seq_len = SEQ_ONE;
               issue          = 1'b1;
               issue_cmd = make_frame(LEN_CODE_9, RELEASE_SELECT, CPHA_CMD,
                  {7'h00, WRITE_EN_OP});
            end
         end

         // read command done: switch to four-frame data groups
         S_RD_CMD: begin
            if (ack_evt) begin
               next_q.st      = S_RD_DATA;
               next_q.seq_len = SEQ_FOUR;
               issue          = 1'b1;
               issue_cmd = make_frame(LEN_CODE_16, HOLD_SELECT, CPHA_DATA,
                  FILLER_WORD);
            end
         end

         // one 16-bit word per frame, groups of four
         S_RD_DATA: begin
            if (ack_evt) begin
               next_q.data      = link_rx;
               next_q.data_addr = q.word_addr;
               next_q.valid     = 1'b1;
               // memory steps its own address, only ours counts here
               next_q.word_addr = q.word_addr + 6'h01;
               // set while the group before the last still runs, so the
               // last group needs no change of settings once started
               // preload final settings
               if (q.group_addr == PRE_FINAL_GROUP) begin
                  next_q.keep_next = {RELEASE_SELECT, {3{HOLD_SELECT}}};
               end
               if (q.frame_idx == q.seq_len) begin
                  next_q.group_addr = q.group_addr + GROUP_STEP;
                  next_q.frame_idx  = 2'h0;
                  // the preloaded settings now apply to the new group
                  next_q.keep_now   = q.keep_next;
               end else begin
                  next_q.frame_idx  = next_idx;
               end
               if (q.frame_idx == q.seq_len &&
                   q.group_addr == FINAL_GROUP) begin
                  next_q.st = S_FINISH;
               end else begin
                  issue = 1'b1;
                  issue_cmd = make_frame(LEN_CODE_16, issue_keep, CPHA_DATA,
                     FILLER_WORD);
               end
            end
         end

         // erase: fixed order of single 9-bit frames, select dropped
         // after each one
         S_ER_WEN: begin
            if (ack_evt) begin
               next_q.st = S_ER_ERASE_ALL_CMD;
               issue     = 1'b1;
               issue_cmd = make_frame(LEN_CODE_9, RELEASE_SELECT, CPHA_CMD,
                  {7'h00, ERASE_ALL_OP});
            end
         end

         // no poll timeout: a memory that never reports done keeps the
         // sequencer busy until reset
         S_ER_ERASE_ALL_CMD, S_ER_POLL: begin
            if (ack_evt) begin
               if (q.st == S_ER_POLL) begin
                  next_q.polls = q.polls + 16'h0001;
               end
               if (q.st == S_ER_POLL && link_rx[8:0] == POLL_DONE) begin
                  next_q.st = S_ER_WDS;
                  issue     = 1'b1;
                  issue_cmd = make_frame(LEN_CODE_9, RELEASE_SELECT,
                     CPHA_CMD, {7'h00, WRITE_DIS_OP});
               end else begin
                  next_q.st = S_ER_POLL;
                  issue     = 1'b1;
                  issue_cmd = make_frame(LEN_CODE_9, RELEASE_SELECT,
                     CPHA_CMD, POLL_WORD);
               end
            end
         end

         // write disable sent, sequence over
         S_ER_WDS: begin
            if (ack_evt) begin
               next_q.st = S_FINISH;
            end
         end

         // one cycle to raise done and drop busy
         S_FINISH: begin
            next_q.done = 1'b1;
            next_q.busy = 1'b0;
            next_q.st   = S_IDLE;
         end
      endcase

      // a new frame changes the command and flips the toggle together;
      // the engine sees the toggle two link edges later, by then stable
      if (issue) begin
         next_q.cmd     = issue_cmd;
         next_q.req_tgl = ~q.req_tgl;
         next_q.pending = 1'b1;
      end
   end

   // the whole state in one register, cleared by the async reset
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // ---------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------
   // serial pins are link-domain registers, passed through unchanged
   // msb first, 2 MHz clock
   assign master_serial_clock_out = pins.master_serial_clock;
   assign mosi_out                = pins.mosi;
   assign slave_select_line_out   = pins.slave_select_line;

   // status and read data straight from sys-domain registers
   assign busy_out                = q.busy;
   assign done_out                = q.done;
   assign rd_data_out             = q.data;
   assign rd_addr_out             = q.data_addr;
   assign rd_valid_out            = q.valid;
   assign poll_count_out          = q.polls;

endmodule

// [testbench/eeprom_seq_props.sv]
`timescale 1ns/1ps
module eeprom_seq_props (
   input wire logic       clk_sys_in,              // system clock
   input wire logic       arst_n_in,               // async reset
   input wire logic       link_clk_in,             // link clock
   input wire logic       start_read_in,           // read request
   input wire logic       start_erase_in,          // erase request
   input wire logic       master_serial_clock_out, // serial clock
   input wire logic       slave_select_line_out,   // select
   input wire logic       busy_out,                // busy level
   input wire logic       done_out,                // done pulse
   input wire logic [5:0] rd_addr_out,             // word address
   input wire logic       rd_valid_out             // word strobe
);
   logic [5:0] prev_addr;
   // ----------------------------------------------------------------
   // helper: last word address, 0x3f so the first word must be 0x00
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) prev_addr <= 6'h3f;
      else if (rd_valid_out) prev_addr <= rd_addr_out;
   end
   addr_ascend_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) rd_valid_out |-> rd_addr_out == prev_addr + 6'h01)
      else $error("word address out of order");
   select_held_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) rd_valid_out && rd_addr_out != 6'h3f
      |-> slave_select_line_out) else $error("select dropped mid read");
   select_release_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) rd_valid_out && rd_addr_out == 6'h3f
      |-> !slave_select_line_out) else $error("select kept after last word");
   select_idle_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) !busy_out |-> !slave_select_line_out)
      else $error("select high while idle");
   clock_idle_a: assert property (@(posedge link_clk_in)
      disable iff (!arst_n_in) !slave_select_line_out
      |-> !master_serial_clock_out) else $error("serial clock outside frame");
   clock_rate_a: assert property (@(posedge link_clk_in)
      disable iff (!arst_n_in) $rose(master_serial_clock_out)
      |-> master_serial_clock_out[*2] ##1 !master_serial_clock_out)
      else $error("serial clock high phase wrong");
   start_taken_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) !busy_out && (start_read_in || start_erase_in)
      |=> busy_out) else $error("start not taken");
   done_pulse_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) done_out |-> !busy_out && $past(busy_out)
      ##1 !done_out) else $error("done not a single end pulse");
   busy_end_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) $fell(busy_out) |-> done_out)
      else $error("busy fell without done");
   valid_busy_a: assert property (@(posedge clk_sys_in)
      disable iff (!arst_n_in) rd_valid_out |-> busy_out)
      else $error("word strobe while idle");
endmodule
bind serial_eeprom_read_erase_seq eeprom_seq_props u_props (
   .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .link_clk_in(link_clk_in),
   .start_read_in(start_read_in), .start_erase_in(start_erase_in),
   .master_serial_clock_out(master_serial_clock_out),
   .slave_select_line_out(slave_select_line_out), .busy_out(busy_out),
   .done_out(done_out), .rd_addr_out(rd_addr_out),
   .rd_valid_out(rd_valid_out));

// [testbench/eeprom_model.sv]
`timescale 1ns/1ps
module eeprom_model (
   input  wire logic sclk_in, // serial clock
   input  wire logic mosi_in, // data in
   input  wire logic sel_in,  // select, high active
   output logic      miso_out // data out
);
   logic [15:0] mem [64];
   logic [8:0]  cmd;
   logic [5:0]  addr;
   logic        reading, wen, bad_order;
   int          nbit, dbit, polls_left;
   // ----------------------------------------------------------------
   // array starts with a known pattern
   // ----------------------------------------------------------------
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 16'h1234 + 16'(i) * 16'h0111;
      {reading, wen, bad_order, miso_out, polls_left} = '0;
   end
   // a new frame restarts command decode; poll answer set up front
   always @(posedge sel_in) begin
      nbit = 0;
      reading = 1'b0;
      miso_out = (polls_left == 0);
   end
   // released line shows the inverse of its last level
   always @(negedge sel_in) miso_out = ~miso_out;
   // command capture on rising edges, data driven on rising edges
   always @(posedge sclk_in) begin
      if (sel_in && nbit < 9) begin
         cmd = {cmd[7:0], mosi_in};
         nbit++;
         if (nbit == 9) begin
            case (cmd)
               9'h180: begin reading = 1'b1; addr = cmd[5:0]; dbit = 0; end
               9'h130: wen = 1'b1;
               9'h120: begin
                  if (!wen) bad_order = 1'b1;
                  else begin
                     for (int i = 0; i < 64; i++) mem[i] = 16'hffff;
                     polls_left = 3;
                  end
               end
               9'h100: begin wen = 1'b0; if (polls_left) bad_order = 1'b1; end
               9'h000: if (polls_left) polls_left--;
               default: bad_order = 1'b1;
            endcase
         end
      end else if (sel_in && reading) begin
         miso_out = mem[addr][15 - dbit];
         dbit++;
         if (dbit == 16) begin dbit = 0; addr++; end
      end
   end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import eeprom_seq_pkg::*;
   logic clk_sys_in = 0, link_clk_in = 0, arst_n_in = 0;
   logic start_read_in = 0, start_erase_in = 0;
   logic miso, sclk, mosi, sel, busy, done, rd_valid;
   logic [15:0] rd_data, poll_count;
   logic [5:0]  rd_addr;
   logic        erased_exp = 0;
   logic [15:0] exp_data;
   int          n_fail = 0, comparisons = 0, n_words = 0;
   // ----------------------------------------------------------------
   // clocks: unrelated periods of 40 ns and 125 ns
   // ----------------------------------------------------------------
   initial forever #20 clk_sys_in = ~clk_sys_in;
   initial begin #7; forever #62.5 link_clk_in = ~link_clk_in; end
   serial_eeprom_read_erase_seq u_dut (.clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in), .link_clk_in(link_clk_in),
      .start_read_in(start_read_in), .start_erase_in(start_erase_in),
      .miso_in(miso), .master_serial_clock_out(sclk), .mosi_out(mosi),
      .slave_select_line_out(sel), .busy_out(busy), .done_out(done),
      .rd_data_out(rd_data), .rd_addr_out(rd_addr), .rd_valid_out(rd_valid),
      .poll_count_out(poll_count));
   eeprom_model u_mem (.sclk_in(sclk), .mosi_in(mosi), .sel_in(sel),
      .miso_out(miso));
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task conclude;
      if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one sequence: pulse the starts, poke a refused start, await done
   task run(input logic rd, input logic er);
      int i;
      @(negedge clk_sys_in) {start_read_in, start_erase_in} = {rd, er};
      @(negedge clk_sys_in) {start_read_in, start_erase_in} = 2'b00;
      repeat (50) @(negedge clk_sys_in);
      {start_read_in, start_erase_in} = 2'b11;
      @(negedge clk_sys_in) {start_read_in, start_erase_in} = 2'b00;
      for (i = 0; i < 40000 && done !== 1'b1; i++) @(negedge clk_sys_in);
      if (i == 40000) begin n_fail++; conclude(); end
      @(negedge clk_sys_in);
   endtask
   // every word strobe is compared against address order and content
   always @(negedge clk_sys_in) begin
      if (rd_valid === 1'b1) begin
         check({10'h000, rd_addr}, 16'(n_words));
         exp_data = 16'h1234 + 16'(n_words) * 16'h0111;
         check(rd_data, erased_exp ? 16'hffff : exp_data);
         n_words++;
      end
   end
   initial begin #3_500_000; n_fail++; conclude(); end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(negedge clk_sys_in);
      arst_n_in = 1;
      repeat (4) @(negedge clk_sys_in);
      run(1'b1, 1'b0);
      check(16'(n_words), 16'd64);
      check({15'h0, sel}, 16'h0000);
      check({15'h0, busy}, 16'h0000);
      n_words = 0;
      run(1'b0, 1'b1);
      check(poll_count, 16'h0004);
      check({15'h0, u_mem.bad_order}, 16'h0000);
      check({15'h0, u_mem.wen}, 16'h0000);
      check(16'(n_words), 16'd0);
      erased_exp = 1;
      run(1'b1, 1'b1);
      check(16'(n_words), 16'd64);
      conclude();
   end
endmodule
